// *** pkg/css_defs.vh ***
// constants for the converter startup sequencer register block
// Functional notes
// - Link run enable 0 halts link state machine; settings may change.
// - Calibration run enable 0 halts calibration machine after link halt.
// - Calibration run enable 1 starts the calibration state machine.
// - Link run enable 1 restarts link state machine.
// - Restarted link follows receiver's SYNC signal.
// - Zero-to-one edge of software trigger starts one calibration.
// - Channel mode switches dual/single by register write only.
// - Single-channel mode samples on both device clock edges.
`ifndef CSS_DEFS_VH
`define CSS_DEFS_VH
`define CSS_ADDR_RUN 4'h0
`define CSS_ADDR_LINK 4'h4
`define CSS_ADDR_CAL 4'h8
`define CSS_ADDR_STAT 4'hC
`define CSS_RUN_LINK 0
`define CSS_RUN_CAL 1
`define CSS_RUN_TRIG 2
`define CSS_RUN_OVR 3
`define CSS_RUN_SINGLE 4
`define CSS_RUN_RST 5'h00
`define CSS_LINK_RST 32'h00000000
`define CSS_CAL_RST 2'h0
`define CSS_CAL_CYCLES 8'h10
`define CSS_RESP_OKAY 2'h0
`define CSS_RESP_SLVERR 2'h2
`endif

// *** logic/css_sequencer.v ***
// register block and link/calibration state machines of the sequencer
`timescale 1ns/1ps
`include "css_defs.vh"
module css_sequencer (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // link side
  input wire sync_n,
  input wire sync_source_in_a,
  input wire sync_source_in_b,
  output reg link_active_q,
  output reg link_data_q,
  output reg cal_busy_q,
  output reg single_channel_q,
  output reg dual_edge_q,
  output reg overrange_enable_q
);
  localparam L_HALT = 2'h0;
  localparam L_CGS = 2'h1;
  localparam L_DATA = 2'h2;
  localparam C_HALT = 2'h0;
  localparam C_IDLE = 2'h1;
  localparam C_RUN = 2'h2;

  reg [4:0] run_q;
  reg [31:0] link_cfg_q;
  reg [1:0] cal_cfg_q;
  reg [1:0] lst_q;
  reg [1:0] cst_q;
  reg [7:0] ccnt_q;
  reg trig_prev_q;
  reg cal_done_q;
  reg [3:0] awaddr_q;
  reg aw_have_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_have_q;
  wire sync_sel;
  wire sync_use;
  wire trig_edge;

  // link config word: [4:0] mode, [12:8] k-1, [16] sync source select
  assign sync_sel = link_cfg_q[16];
  // sync source: 0 single-ended sync, 1 timestamp differential pair
  assign sync_use = sync_sel ? ~(sync_source_in_a & ~sync_source_in_b)
                             : sync_n;
  assign trig_edge = run_q[`CSS_RUN_TRIG] & ~trig_prev_q;

  // --------------------------------------------------------------
  // axi write channel
  // --------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CSS_RESP_OKAY;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      run_q <= `CSS_RUN_RST;
      link_cfg_q <= `CSS_LINK_RST;
      cal_cfg_q <= `CSS_CAL_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_have_q && w_have_q && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `CSS_RESP_OKAY;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        case (awaddr_q)
          `CSS_ADDR_RUN: begin
            // run enables, trigger, overrange and channel mode
            if (wstrb_q[0])
              run_q <= wdata_q[4:0];
          end
          `CSS_ADDR_LINK: begin
            if (wstrb_q[0])
              link_cfg_q[7:0] <= wdata_q[7:0];
            if (wstrb_q[1])
              link_cfg_q[15:8] <= wdata_q[15:8];
            if (wstrb_q[2])
              link_cfg_q[23:16] <= wdata_q[23:16];
            if (wstrb_q[3])
              link_cfg_q[31:24] <= wdata_q[31:24];
          end
          `CSS_ADDR_CAL: begin
            // bit0 background mode, bit1 offset calibration
            if (wstrb_q[0])
              cal_cfg_q <= wdata_q[1:0];
          end
          `CSS_ADDR_STAT: begin
            s_axi_bresp <= `CSS_RESP_SLVERR;
          end
          default: begin
            s_axi_bresp <= `CSS_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------
  // axi read channel
  // --------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CSS_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CSS_RESP_OKAY;
        case (s_axi_araddr)
          `CSS_ADDR_RUN: s_axi_rdata <= {27'h0, run_q};
          `CSS_ADDR_LINK: s_axi_rdata <= link_cfg_q;
          `CSS_ADDR_CAL: s_axi_rdata <= {30'h0, cal_cfg_q};
          `CSS_ADDR_STAT: begin
            s_axi_rdata <= {24'h000000, cal_done_q, sync_use, cst_q,
                            2'h0, lst_q};
          end
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CSS_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------
  // link state machine
  // --------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      lst_q <= L_HALT;
    end else if (!run_q[`CSS_RUN_LINK]) begin
      lst_q <= L_HALT;
    end else begin
      case (lst_q)
        L_HALT: lst_q <= L_CGS;
        // sync low requests resynchronisation from the receiver
        L_CGS: if (sync_use) lst_q <= L_DATA;
        L_DATA: if (!sync_use) lst_q <= L_CGS;
        default: lst_q <= L_HALT;
      endcase
    end
  end

  // --------------------------------------------------------------
  // calibration state machine
  // --------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      cst_q <= C_HALT;
      ccnt_q <= 8'h00;
      trig_prev_q <= 1'b0;
      cal_done_q <= 1'b0;
    end else begin
      trig_prev_q <= run_q[`CSS_RUN_TRIG];
      if (!run_q[`CSS_RUN_CAL]) begin
        cst_q <= C_HALT;
        ccnt_q <= 8'h00;
      end else begin
        case (cst_q)
          C_HALT: cst_q <= C_IDLE;
          C_IDLE: begin
            // edges seen while halted are dropped, not queued
            if (trig_edge) begin
              cst_q <= C_RUN;
              ccnt_q <= `CSS_CAL_CYCLES;
              cal_done_q <= 1'b0;
            end
          end
          C_RUN: begin
            if (ccnt_q == 8'h01) begin
              cst_q <= C_IDLE;
              cal_done_q <= 1'b1;
            end
            ccnt_q <= ccnt_q - 8'h01;
          end
          default: cst_q <= C_HALT;
        endcase
      end
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      link_active_q <= 1'b0;
      link_data_q <= 1'b0;
      cal_busy_q <= 1'b0;
      single_channel_q <= 1'b0;
      dual_edge_q <= 1'b0;
      overrange_enable_q <= 1'b0;
    end else begin
      link_active_q <= (lst_q != L_HALT);
      link_data_q <= (lst_q == L_DATA);
      cal_busy_q <= (cst_q == C_RUN);
      single_channel_q <= run_q[`CSS_RUN_SINGLE];
      // both edges in single mode keeps the device clock unchanged
      dual_edge_q <= run_q[`CSS_RUN_SINGLE];
      overrange_enable_q <= run_q[`CSS_RUN_OVR];
    end
  end
endmodule

// *** tb/css_seq_asserts.sv ***
// port checker for the startup sequencer
`timescale 1ns/1ps
module css_seq_asserts (
  // clock, reset
  input wire aclk,
  input wire aresetn,
  // bus
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  // link
  input wire sync_n,
  input wire link_active_q,
  input wire link_data_q,
  input wire cal_busy_q,
  input wire single_channel_q,
  input wire dual_edge_q
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----
  // checks
  // ----
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  bus_busy_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("ready in response");
  r_next_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  data_active_a: assert property (
    link_data_q |-> link_active_q)
    else $error("data while halted");
  sync_follow_a: assert property (
    (link_active_q && sync_n) [*3] |-> link_data_q)
    else $error("no data state");
  resync_drop_a: assert property (
    link_data_q && !sync_n |-> ##[1:2] !link_data_q)
    else $error("no resync");
  cal_time_a: assert property (
    $rose(cal_busy_q) |->
      cal_busy_q [*8] ##1 cal_busy_q [*8] ##1 !cal_busy_q)
    else $error("cal length");
  mode_edge_a: assert property (
    dual_edge_q == single_channel_q)
    else $error("edge mode");
  cover property ($rose(cal_busy_q));
  cover property ($rose(link_data_q));
  cover property ($rose(single_channel_q));
endmodule
bind css_sequencer css_seq_asserts chk (.*);

// *** tb/css_link_rx.sv ***
// link receiver model driving the sync request
`timescale 1ns/1ps
module css_link_rx #(
  parameter LAG = 4
) (
  // clock
  input wire aclk,
  // link state
  input wire link_active_q,
  // forced resync
  input wire drop,
  // sync lines
  output wire sync_n,
  output wire sync_source_in_a,
  output wire sync_source_in_b
);
  reg [3:0] cnt_q;
  wire req;
  // request held while halted and for LAG cycles after start, so the
  // transmitter cannot leave code group sync on a stale sync level;
  // both sources carry the same request
  assign req = drop || (cnt_q != LAG);
  assign sync_n = !req;
  assign sync_source_in_a = req;
  assign sync_source_in_b = !req;
  always @(posedge aclk) begin
    if (!link_active_q || drop) cnt_q <= 4'h0;
    else if (cnt_q != LAG) cnt_q <= cnt_q + 4'h1;
  end
endmodule

// *** tb/converter_startup_sequencer_tb.sv ***
// bench: host startup sequence over the register bus
`timescale 1ns/1ps
`include "css_defs.vh"
module converter_startup_sequencer_tb;
  reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg s_axi_arvalid, s_axi_rready, drop;
  reg [3:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata;
  wire [3:0] s_axi_wstrb = 4'hF;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, sync_n, sync_source_in_a, sync_source_in_b;
  wire link_active_q, link_data_q, cal_busy_q;
  wire single_channel_q, dual_edge_q, overrange_enable_q;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  logic [1:0] rs, rr;
  int n_errors = 0;
  int cmp_count = 0;
  css_sequencer DUT (.*);
  css_link_rx #(.LAG(4)) rx (.*);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    end_sim;
  end
  // ----
  // tasks
  // ----
  task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rchk(input string n, input logic [3:0] a, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    cmp(n, e, s_axi_rdata);
  endtask
  task end_sim;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, drop} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("run", `CSS_ADDR_RUN, 32'h0);
    wr(`CSS_ADDR_RUN, 32'h0);
    cmp("bresp", {30'h0, `CSS_RESP_OKAY}, {30'h0, rs});
    wr(`CSS_ADDR_RUN, 32'h0);
    wr(`CSS_ADDR_LINK, 32'h00011F02);
    rchk("link", `CSS_ADDR_LINK, 32'h00011F02);
    wr(`CSS_ADDR_CAL, 32'h3);
    rchk("cal", `CSS_ADDR_CAL, 32'h3);
    wr(`CSS_ADDR_RUN, 32'h2);
    rchk("stat", `CSS_ADDR_STAT, 32'h10);
    wr(`CSS_ADDR_RUN, 32'hA);
    @(posedge aclk);
    cmp("ovr", 32'h1, {31'h0, overrange_enable_q});
    wr(`CSS_ADDR_RUN, 32'hB);
    repeat (2) @(posedge aclk);
    cmp("cgs", 32'h2, {30'h0, link_active_q, link_data_q});
    repeat (12) @(posedge aclk);
    cmp("data", 32'h3, {30'h0, link_active_q, link_data_q});
    drop <= 1'b1;
    repeat (3) @(posedge aclk);
    cmp("resync", 32'h2, {30'h0, link_active_q, link_data_q});
    drop <= 1'b0;
    wr(`CSS_ADDR_RUN, 32'hB);
    wr(`CSS_ADDR_RUN, 32'hF);
    repeat (2) @(posedge aclk);
    cmp("busy", 32'h1, {31'h0, cal_busy_q});
    for (int i = 0; i < 40 && cal_busy_q === 1'b1; i++) @(posedge aclk);
    rchk("stat", `CSS_ADDR_STAT, 32'hD2);
    wr(`CSS_ADDR_RUN, 32'h1F);
    repeat (2) @(posedge aclk);
    cmp("mode", 32'h3, {30'h0, single_channel_q, dual_edge_q});
    wr(`CSS_ADDR_RUN, 32'hF);
    repeat (2) @(posedge aclk);
    cmp("mode", 32'h0, {30'h0, single_channel_q, dual_edge_q});
    // halt, switch to the single-ended sync input and restart
    wr(`CSS_ADDR_RUN, 32'hE);
    repeat (2) @(posedge aclk);
    cmp("halt", 32'h0, {30'h0, link_active_q, link_data_q});
    wr(`CSS_ADDR_RUN, 32'hC);
    wr(`CSS_ADDR_LINK, 32'h00001F02);
    wr(`CSS_ADDR_RUN, 32'hE);
    wr(`CSS_ADDR_RUN, 32'hF);
    repeat (12) @(posedge aclk);
    cmp("data", 32'h3, {30'h0, link_active_q, link_data_q});
    rchk("stat", `CSS_ADDR_STAT, 32'hD2);
    // unmapped offset reads zero with an error response
    rchk("hole", 4'h2, 32'h0);
    cmp("rresp", {30'h0, `CSS_RESP_SLVERR}, {30'h0, rr});
    // status is read-only, so this write must be refused
    wr(`CSS_ADDR_STAT, 32'h0);
    cmp("bresp", {30'h0, `CSS_RESP_SLVERR}, {30'h0, rs});
    end_sim;
  end
endmodule
